// [hdl/cpb_pkg.sv]
/*
 * Constants and types of the clip payload builder.
 * Assumes users scope every name; nothing is imported.
 */
package cpb_pkg;

    // Topology codes
    localparam logic [4:0] KIND_POINT_SEQ = 5'h01;
    localparam logic [4:0] KIND_SEGMENT_PAIRS = 5'h02;
    localparam logic [4:0] KIND_SEGMENT_CHAIN = 5'h03;
    localparam logic [4:0] KIND_CLOSED_SEGMENT_RING = 5'h04;
    localparam logic [4:0] KIND_TRIANGLE_TRIPLES = 5'h05;
    localparam logic [4:0] KIND_TRIANGLE_CHAIN = 5'h06;
    localparam logic [4:0] KIND_TRIANGLE_FAN = 5'h07;
    localparam logic [4:0] KIND_FOUR_CORNER_LIST = 5'h08;
    localparam logic [4:0] KIND_FOUR_CORNER_CHAIN = 5'h09;
    localparam logic [4:0] KIND_POLYGON = 5'h0C;
    localparam logic [4:0] KIND_RECTANGLE_TRIPLES = 5'h0F;
    localparam logic [4:0] KIND_SEGMENT_PAIRS_NB = 5'h10;
    localparam logic [4:0] KIND_SEGMENT_CHAIN_NB = 5'h11;
    localparam logic [4:0] KIND_TRIANGLE_TRIPLES_NB = 5'h12;
    localparam logic [4:0] KIND_TRIANGLE_CHAIN_NB = 5'h13;
    localparam logic [4:0] KIND_TRIANGLE_CHAIN_FLIPPED = 5'h14;
    localparam logic [4:0] KIND_TRIANGLE_FAN_UNPATTERNED = 5'h15;
    localparam logic [4:0] KIND_SEGMENT_CHAIN_BACKFACE = 5'h16;
    localparam logic [4:0] KIND_SEGMENT_CHAIN_CONTINUED = 5'h17;
    localparam logic [4:0] KIND_SEGMENT_CHAIN_CONT_BACKFACE = 5'h18;
    localparam logic [4:0] KIND_POINT_SEQ_BACKFACE = 5'h19;

    // clip_action_select codes
    localparam logic [1:0] ACT_PASS = 2'h0;
    localparam logic [1:0] ACT_DISCARD = 2'h1;
    localparam logic [1:0] ACT_SPAWN = 2'h2;

    // Primitive sizing
    localparam int MAX_VERTS = 64;

    // Header field positions
    localparam int DW2_OUTCODE_LSB = 13;
    localparam int DW4_BIND_LSB = 5;
    localparam int DW5_SCRATCH_LSB = 10;
    localparam logic [3:0] SCRATCH_SIZE_MAX = 4'hB;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SCRATCH_BASE = 8'h04;
    localparam logic [7:0] REG_BIND_BASE = 8'h08;
    localparam logic [7:0] REG_SCRATCH_SIZE = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_THREAD_ID = 8'h14;
    localparam logic CTRL_ENABLE_RST = 1'b0;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic [3:0] SCRATCH_SIZE_RST = 4'h0;

    // Strip labelling
    localparam logic [1:0] STRIP_NONE = 2'h0;
    localparam logic [1:0] STRIP_PLAIN_FIRST = 2'h1;
    localparam logic [1:0] STRIP_FLIP_FIRST = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FORM = 3'b010,
        ST_WAIT = 3'b100
    } cpb_state_t;

    typedef struct packed {
        logic supported;
        logic [2:0] stride;
        logic [2:0] off0;
        logic [2:0] off1;
        logic [2:0] off2;
        logic [2:0] span;
        logic [1:0] nv;
        logic fan;
        logic [1:0] strip;
        logic [4:0] pass_kind;
    } cpb_shape_t;

    // Object shape per topology; unknown, closed-ring and four-corner codes form no objects
    function automatic cpb_shape_t shape_of(input logic [4:0] kind);
        cpb_shape_t s;
        s = '{1'b1, 3'h1, 3'h0, 3'h1, 3'h2, 3'h0, 2'h1, 1'b0,
              STRIP_NONE, kind};
        case (kind)
            KIND_POINT_SEQ, KIND_POINT_SEQ_BACKFACE:
                s.span = 3'h0;
            KIND_SEGMENT_PAIRS:
            begin
                s.stride = 3'h2;
                s.span = 3'h1;
                s.nv = 2'h2;
            end
            KIND_SEGMENT_PAIRS_NB:
            begin
                s = '{1'b1, 3'h4, 3'h1, 3'h2, 3'h0, 3'h3, 2'h2, 1'b0,
                      STRIP_NONE, KIND_SEGMENT_PAIRS};
            end
            KIND_SEGMENT_CHAIN, KIND_SEGMENT_CHAIN_BACKFACE,
            KIND_SEGMENT_CHAIN_CONTINUED, KIND_SEGMENT_CHAIN_CONT_BACKFACE:
            begin
                s.span = 3'h1;
                s.nv = 2'h2;
            end
            KIND_SEGMENT_CHAIN_NB:
            begin
                s = '{1'b1, 3'h1, 3'h1, 3'h2, 3'h0, 3'h3, 2'h2, 1'b0,
                      STRIP_NONE, KIND_SEGMENT_CHAIN};
            end
            KIND_TRIANGLE_TRIPLES, KIND_RECTANGLE_TRIPLES:
            begin
                s.stride = 3'h3;
                s.span = 3'h2;
                s.nv = 2'h3;
            end
            KIND_TRIANGLE_TRIPLES_NB:
            begin
                s = '{1'b1, 3'h6, 3'h0, 3'h2, 3'h4, 3'h5, 2'h3, 1'b0,
                      STRIP_NONE, KIND_TRIANGLE_TRIPLES};
            end
            KIND_TRIANGLE_CHAIN, KIND_TRIANGLE_CHAIN_FLIPPED:
            begin
                s.span = 3'h2;
                s.nv = 2'h3;
                s.strip = (kind == KIND_TRIANGLE_CHAIN) ?
                    STRIP_PLAIN_FIRST : STRIP_FLIP_FIRST;
            end
            KIND_TRIANGLE_CHAIN_NB:
            begin
                s = '{1'b1, 3'h2, 3'h0, 3'h2, 3'h4, 3'h5, 2'h3, 1'b0,
                      STRIP_PLAIN_FIRST, KIND_TRIANGLE_CHAIN};
            end
            KIND_TRIANGLE_FAN, KIND_TRIANGLE_FAN_UNPATTERNED, KIND_POLYGON:
            begin
                s.span = 3'h2;
                s.nv = 2'h3;
                s.fan = 1'b1;
            end
            default:
                s.supported = 1'b0;
        endcase
        return s;
    endfunction

endpackage

// [hdl/cpb_payload_builder.sv]
/*
 * Clip-stage object former and thread header builder.
 * Each object is passed, discarded or spawned as decided.
 * AHB-Lite registers hold the header fields except the dword 2 outcodes.
 * Assumes all neighbours run on core_clk_i.
 */
`timescale 1ns/1ns

// Notes on behaviour
// - Pass kind: input kind; neighbor kinds go plain.
// - Passed chain label follows object position in strip.
// - Thread kind is input kind; chains get per-object labels.
// - Point kinds: object k is vertex k.
// - Segment pairs: object k is vertices 2k, 2k+1.
// - Segment chains: object k is k, k+1.
// - Neighbor segments: 4k+1,4k+2 or k+1,k+2; free neighbors.
// - Triangle and rectangle triples: 3k, 3k+1, 3k+2.
// - Neighbor triples: 6k, 6k+2, 6k+4; free odd vertices.
// - Plain chain: k, k+1, k+2; even plain, odd flipped.
// - Flipped chain: k, k+1, k+2; even flipped, odd plain.
// - Neighbor chain: 2k, 2k+2, 2k+4; even plain, odd flipped.
// - Fans and polygons: 0, k+1, k+2.
// - Dword 6 bits 23:0: unique thread id.
// - Dword 5 bits 31:10: scratch offset.
// - Dword 5 bits 7:0: local tag that frees the thread.
// - Dword 4 bits 31:5: binding table offset.
// - Dword 3 bits 3:0: scratch size code 0 to 11.
// - Dword 2 bits 31:22: viewport, guard band ORs.
// - Dword 2 bits 21:14 user plane ORs, 13 invalid OR.
module cpb_payload_builder (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Primitive header
    input wire logic prim_valid_i,
    input wire logic [4:0] primitive_kind_i,
    input wire logic [6:0] prim_count_i,
    output logic prim_ready_o,
    // Per-vertex outcodes
    input wire logic vtx_valid_i,
    input wire logic [18:0] vtx_outcode_i,
    output logic vtx_ready_o,
    // Object offer
    output logic obj_valid_o,
    output logic [5:0] obj_v0_o,
    output logic [5:0] obj_v1_o,
    output logic [5:0] obj_v2_o,
    output logic [1:0] obj_nverts_o,
    output logic [18:0] obj_or_code_o,
    input wire logic decision_valid_i,
    input wire logic [1:0] clip_action_select_i,
    // Neighbor release
    output logic release_valid_o,
    output logic [5:0] release_base_o,
    output logic [5:0] release_mask_o,
    // Pass-through
    output logic pass_valid_o,
    output logic [4:0] pass_kind_o,
    // Spawned thread request
    output logic spawn_valid_o,
    output logic [4:0] object_kind_field_o,
    output logic [31:0] hdr_dw2_o,
    output logic [31:0] hdr_dw3_o,
    output logic [31:0] hdr_dw4_o,
    output logic [31:0] hdr_dw5_o,
    output logic [31:0] hdr_dw6_o,
    // Thread completion
    input wire logic thread_done_i
);

    // Registers and bus state
    logic ctrl_enable_q;
    logic [31:0] scratch_base_q;
    logic [31:0] bind_base_q;
    logic [3:0] scratch_size_q;
    logic [23:0] thread_id_q;
    logic [8:0] outstanding_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;

    // Primitive and object state
    cpb_pkg::cpb_state_t state_q;
    cpb_pkg::cpb_state_t state_d;
    logic [4:0] kind_q;
    logic [6:0] count_q;
    logic [6:0] wptr_q;
    logic [6:0] wptr_d;
    logic [6:0] base_q;
    logic parity_q;
    logic [18:0] outcode_mem [cpb_pkg::MAX_VERTS];

    // Bus decode
    wire logic addr_phase = hsel_i & htrans_i[1] & hready_i;
    wire logic [7:0] addr_lo = haddr_i[7:0];
    wire logic addr_hit = (haddr_i[31:8] == 24'h00_0000);
    wire logic [31:0] rd_mux =
        !addr_hit ? 32'h0 :
        (addr_lo == cpb_pkg::REG_CTRL) ? {31'h0, ctrl_enable_q} :
        (addr_lo == cpb_pkg::REG_SCRATCH_BASE) ?
            {scratch_base_q[31:10], 10'h000} :
        (addr_lo == cpb_pkg::REG_BIND_BASE) ? {bind_base_q[31:5], 5'h00} :
        (addr_lo == cpb_pkg::REG_SCRATCH_SIZE) ? {28'h0, scratch_size_q} :
        (addr_lo == cpb_pkg::REG_STATUS) ?
            {20'h0, state_q, outstanding_q} :
        (addr_lo == cpb_pkg::REG_THREAD_ID) ? {8'h00, thread_id_q} :
        32'h0;
    wire logic wr_now = wr_pend_q;
    // Oversized codes saturate
    wire logic [3:0] size_wr = (hwdata_i[3:0] > cpb_pkg::SCRATCH_SIZE_MAX) ?
        cpb_pkg::SCRATCH_SIZE_MAX : hwdata_i[3:0];

    // Current object geometry
    wire cpb_pkg::cpb_shape_t shape = cpb_pkg::shape_of(kind_q);
    wire logic [6:0] last_idx = base_q + {4'h0, shape.span};
    wire logic obj_exists = shape.supported && (last_idx < count_q);
    wire logic obj_ready = wptr_q > last_idx;
    // Fans pin vertex 0
    wire logic [6:0] idx0 = shape.fan ? 7'h00 :
        base_q + {4'h0, shape.off0};
    wire logic [6:0] idx1 = base_q + {4'h0, shape.off1};
    wire logic [6:0] idx2 = base_q + {4'h0, shape.off2};
    wire logic [18:0] oc0 = outcode_mem[idx0[5:0]];
    wire logic [18:0] oc1 = outcode_mem[idx1[5:0]];
    wire logic [18:0] oc2 = outcode_mem[idx2[5:0]];
    wire logic [18:0] or_code = oc0 |
        ((shape.nv > 2'h1) ? oc1 : 19'h0) |
        ((shape.nv > 2'h2) ? oc2 : 19'h0);

    // Neighbor release at offer
    wire logic chain_first = (base_q == 7'h00);
    wire logic chain_last = (last_idx == count_q - 7'h01);
    wire logic [5:0] rel_mask =
        (kind_q == cpb_pkg::KIND_SEGMENT_PAIRS_NB) ? 6'h09 :
        (kind_q == cpb_pkg::KIND_SEGMENT_CHAIN_NB) ?
            {2'h0, chain_last, 2'h0, chain_first} :
        (kind_q == cpb_pkg::KIND_TRIANGLE_TRIPLES_NB) ? 6'h2A :
        (kind_q == cpb_pkg::KIND_TRIANGLE_CHAIN_NB) ?
            {chain_last, 1'b0, chain_last, 1'b0, 1'b1, 1'b0} :
        6'h00;

    // Strip label from object parity
    wire logic flipped = (shape.strip == cpb_pkg::STRIP_FLIP_FIRST) ?
        ~parity_q : parity_q;
    wire logic [4:0] strip_label = flipped ?
        cpb_pkg::KIND_TRIANGLE_CHAIN_FLIPPED : cpb_pkg::KIND_TRIANGLE_CHAIN;
    wire logic is_strip = (shape.strip != cpb_pkg::STRIP_NONE);
    wire logic [4:0] obj_kind = is_strip ? strip_label : kind_q;
    wire logic [4:0] out_kind = is_strip ? strip_label :
        shape.pass_kind;

    // Sequencing
    wire logic prim_take = prim_ready_o & prim_valid_i;
    wire logic vtx_take = vtx_ready_o & vtx_valid_i;
    wire logic form_now = (state_q == cpb_pkg::ST_FORM) & obj_exists &
        obj_ready;
    wire logic prim_done = (state_q == cpb_pkg::ST_FORM) & ~obj_exists &
        (wptr_q == count_q);
    wire logic decided = (state_q == cpb_pkg::ST_WAIT) & decision_valid_i;
    wire logic do_pass = decided &
        (clip_action_select_i == cpb_pkg::ACT_PASS);
    wire logic do_spawn = decided &
        (clip_action_select_i == cpb_pkg::ACT_SPAWN);
    wire logic [6:0] count_d = prim_take ? prim_count_i : count_q;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            cpb_pkg::ST_IDLE:
                if (prim_take)
                    state_d = cpb_pkg::ST_FORM;
            cpb_pkg::ST_FORM:
                if (form_now)
                    state_d = cpb_pkg::ST_WAIT;
                else if (prim_done)
                    state_d = cpb_pkg::ST_IDLE;
            cpb_pkg::ST_WAIT:
                if (decided)
                    state_d = cpb_pkg::ST_FORM;
        endcase
    end

    always_comb
    begin
        wptr_d = wptr_q;
        if (prim_take)
            wptr_d = 7'h00;
        else if (vtx_take)
            wptr_d = wptr_q + 7'h01;
    end

    // Zero wait states; read data taken in address phase
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_o <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
        else
        begin
            wr_pend_q <= addr_phase & hwrite_i & addr_hit;
            if (addr_phase)
                wr_addr_q <= addr_lo;
            if (addr_phase & ~hwrite_i)
                hrdata_o <= rd_mux;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_enable_q <= cpb_pkg::CTRL_ENABLE_RST;
            scratch_base_q <= cpb_pkg::BASE_RST;
            bind_base_q <= cpb_pkg::BASE_RST;
            scratch_size_q <= cpb_pkg::SCRATCH_SIZE_RST;
        end
        else if (wr_now)
        begin
            if (wr_addr_q == cpb_pkg::REG_CTRL)
                ctrl_enable_q <= hwdata_i[0];
            if (wr_addr_q == cpb_pkg::REG_SCRATCH_BASE)
                scratch_base_q <= hwdata_i;
            if (wr_addr_q == cpb_pkg::REG_BIND_BASE)
                bind_base_q <= hwdata_i;
            if (wr_addr_q == cpb_pkg::REG_SCRATCH_SIZE)
                scratch_size_q <= size_wr;
        end
    end

    // Not reset: written before any read
    always_ff @(posedge core_clk_i)
    begin
        if (vtx_take)
            outcode_mem[wptr_q[5:0]] <= vtx_outcode_i;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= cpb_pkg::ST_IDLE;
            kind_q <= 5'h00;
            count_q <= 7'h00;
            wptr_q <= 7'h00;
            base_q <= 7'h00;
            parity_q <= 1'b0;
            prim_ready_o <= 1'b0;
            vtx_ready_o <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            wptr_q <= wptr_d;
            count_q <= count_d;
            if (prim_take)
            begin
                kind_q <= primitive_kind_i;
                base_q <= 7'h00;
                parity_q <= 1'b0;
            end
            else if (decided)
            begin
                base_q <= base_q + {4'h0, shape.stride};
                parity_q <= ~parity_q;
            end
            prim_ready_o <= (state_d == cpb_pkg::ST_IDLE) & ctrl_enable_q;
            vtx_ready_o <= (state_d != cpb_pkg::ST_IDLE) & (wptr_d < count_d);
        end
    end

    // Object offer and neighbor release
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            obj_valid_o <= 1'b0;
            obj_v0_o <= 6'h00;
            obj_v1_o <= 6'h00;
            obj_v2_o <= 6'h00;
            obj_nverts_o <= 2'h0;
            obj_or_code_o <= 19'h0;
            object_kind_field_o <= 5'h00;
            pass_kind_o <= 5'h00;
            release_valid_o <= 1'b0;
            release_base_o <= 6'h00;
            release_mask_o <= 6'h00;
        end
        else
        begin
            release_valid_o <= form_now & (rel_mask != 6'h00);
            if (decided)
                obj_valid_o <= 1'b0;
            if (form_now)
            begin
                obj_valid_o <= 1'b1;
                obj_v0_o <= idx0[5:0];
                obj_v1_o <= idx1[5:0];
                obj_v2_o <= idx2[5:0];
                obj_nverts_o <= shape.nv;
                obj_or_code_o <= or_code;
                object_kind_field_o <= obj_kind;
                pass_kind_o <= out_kind;
                release_base_o <= base_q[5:0];
                release_mask_o <= rel_mask;
            end
        end
    end

    // Header from the latched object
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pass_valid_o <= 1'b0;
            spawn_valid_o <= 1'b0;
            hdr_dw2_o <= 32'h0;
            hdr_dw3_o <= 32'h0;
            hdr_dw4_o <= 32'h0;
            hdr_dw5_o <= 32'h0;
            hdr_dw6_o <= 32'h0;
            thread_id_q <= 24'h0;
            outstanding_q <= 9'h0;
        end
        else
        begin
            pass_valid_o <= do_pass;
            spawn_valid_o <= do_spawn;
            if (do_spawn)
            begin
                hdr_dw2_o <= {obj_or_code_o, 13'h0000};
                hdr_dw3_o <= {28'h0, scratch_size_q};
                hdr_dw4_o <= {bind_base_q[31:5], 5'h00};
                hdr_dw5_o <= {scratch_base_q[31:10], 2'h0,
                              thread_id_q[7:0]};
                hdr_dw6_o <= {8'h00, thread_id_q};
                thread_id_q <= thread_id_q + 24'h1;
            end
            // Spawn and completion in one cycle cancel out
            if (do_spawn & ~thread_done_i)
                outstanding_q <= outstanding_q + 9'h001;
            else if (~do_spawn & thread_done_i & (outstanding_q != 9'h000))
                outstanding_q <= outstanding_q - 9'h001;
        end
    end

endmodule // cpb_payload_builder

// [tb/cpb_checker_sva.sv]
/* Port checker, bound at the foot.
   Assumes one clock, async low reset. */
`timescale 1ns/1ns
module cpb_checker (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic obj_valid_o,
    input wire logic [18:0] obj_or_code_o,
    input wire logic decision_valid_i,
    input wire logic [1:0] clip_action_select_i,
    input wire logic pass_valid_o,
    input wire logic [4:0] pass_kind_o,
    input wire logic spawn_valid_o,
    input wire logic [31:0] hdr_dw2_o,
    input wire logic [31:0] hdr_dw3_o,
    input wire logic [31:0] hdr_dw4_o,
    input wire logic [31:0] hdr_dw5_o,
    input wire logic [31:0] hdr_dw6_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_PASS_DEC: assert property (
        decision_valid_i && obj_valid_o && clip_action_select_i == 2'h0
        |=> pass_valid_o && !spawn_valid_o) else $error("no pass");
    AST_SPAWN_DEC: assert property (
        decision_valid_i && obj_valid_o && clip_action_select_i == 2'h2
        |=> spawn_valid_o && !pass_valid_o) else $error("no spawn");
    AST_EMIT_CAUSE: assert property (
        pass_valid_o || spawn_valid_o
        |-> $past(decision_valid_i) && $past(obj_valid_o))
        else $error("emit without decision");
    AST_OBJ_HOLD: assert property (
        obj_valid_o && !decision_valid_i
        |=> obj_valid_o && $stable(obj_or_code_o)) else $error("obj moved");
    AST_PASS_PLAIN: assert property (
        pass_valid_o |-> pass_kind_o < 5'h10 || pass_kind_o > 5'h13)
        else $error("neighbor kind passed");
    AST_DW2_OR: assert property (
        spawn_valid_o |-> hdr_dw2_o[31:13] == $past(obj_or_code_o))
        else $error("outcode hints wrong");
    AST_RSVD: assert property (
        spawn_valid_o |-> hdr_dw3_o[31:4] == 28'h0 && hdr_dw4_o[4:0] == 5'h0
        && hdr_dw5_o[9:8] == 2'h0 && hdr_dw6_o[31:24] == 8'h0)
        else $error("reserved bits set");
    AST_SIZE: assert property (
        spawn_valid_o |-> hdr_dw3_o[3:0] <= 4'hB) else $error("size code");
    AST_TAG: assert property (
        spawn_valid_o |-> hdr_dw5_o[7:0] == hdr_dw6_o[7:0])
        else $error("tag differs from id");
endmodule // cpb_checker

bind cpb_payload_builder cpb_checker u_chk (.core_clk_i, .nrst_i,
    .obj_valid_o, .obj_or_code_o, .decision_valid_i, .clip_action_select_i,
    .pass_valid_o, .pass_kind_o, .spawn_valid_o, .hdr_dw2_o, .hdr_dw3_o,
    .hdr_dw4_o, .hdr_dw5_o, .hdr_dw6_o);

// [tb/cpb_decider.sv]
/* Decider model: answers after 0 or 2 waits;
   ends each thread at once. */
`timescale 1ns/1ns
module cpb_decider (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic obj_valid_o,
    input wire logic spawn_valid_o,
    output logic decision_valid_i,
    output logic [1:0] clip_action_select_i,
    output logic thread_done_i
);
    logic [1:0] wait_q;
    logic [2:0] seq_q;
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            decision_valid_i <= 1'b0;
            clip_action_select_i <= 2'h0;
            thread_done_i <= 1'b0;
            wait_q <= 2'h0;
            seq_q <= 3'h0;
        end
        else
        begin
            thread_done_i <= spawn_valid_o;
            if (decision_valid_i)
            begin
                decision_valid_i <= 1'b0;
                wait_q <= 2'h0;
                seq_q <= (seq_q == 3'h4) ? 3'h0 : seq_q + 3'h1;
            end
            else if (obj_valid_o && wait_q >= {seq_q[0], 1'b0})
            begin
                decision_valid_i <= 1'b1;
                // Five-step cycle shifts the pattern across strips
                clip_action_select_i <= 2'(10'h098 >> {seq_q, 1'b0});
            end
            else if (obj_valid_o)
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule // cpb_decider

// [tb/clip_passthru_payload_builder_test.sv]
/* Bench: one primitive per supported kind, every decision checked.
   Assumes the decider model. */
`timescale 1ns/1ns
module clip_passthru_payload_builder_test;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic prim_valid_i = 1'b0;
    logic vtx_valid_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [4:0] primitive_kind_i = 5'h0;
    logic [6:0] prim_count_i = 7'h0;
    logic [18:0] vtx_outcode_i = 19'h0;
    wire logic hreadyout_o, prim_ready_o, vtx_ready_o, obj_valid_o;
    wire logic decision_valid_i, pass_valid_o, spawn_valid_o, thread_done_i;
    wire logic [1:0] obj_nverts_o, clip_action_select_i;
    wire logic [4:0] pass_kind_o, object_kind_field_o;
    wire logic [5:0] obj_v0_o, obj_v1_o, obj_v2_o, rm;
    wire logic [18:0] obj_or_code_o;
    wire logic [31:0] hrdata_o, hdr_dw2_o, hdr_dw3_o, hdr_dw4_o;
    wire logic [31:0] hdr_dw5_o, hdr_dw6_o;
    int miscompares = 0, tests_run = 0, cyc = 0, j = 0;
    logic [4:0] ck = 5'h0, pl;
    logic [1:0] pa;
    logic pend = 1'b0;
    // Legal kinds and counts only
    logic [4:0] kinds [18] = '{5'h01, 5'h19, 5'h02, 5'h10, 5'h03, 5'h16,
        5'h17, 5'h18, 5'h11, 5'h05, 5'h0F, 5'h12, 5'h06, 5'h14, 5'h13,
        5'h07, 5'h15, 5'h0C};
    int cnts [18] = '{4, 3, 4, 8, 5, 3, 3, 3, 6, 6, 3, 12, 6, 5, 10, 5, 4, 4};
    cpb_payload_builder dut (.core_clk_i, .nrst_i, .hsel_i(1'b1), .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
        .hready_i(hreadyout_o), .hreadyout_o, .hresp_o(), .hrdata_o,
        .prim_valid_i, .primitive_kind_i, .prim_count_i, .prim_ready_o,
        .vtx_valid_i, .vtx_outcode_i, .vtx_ready_o, .obj_valid_o, .obj_v0_o,
        .obj_v1_o, .obj_v2_o, .obj_nverts_o, .obj_or_code_o,
        .decision_valid_i, .clip_action_select_i, .release_valid_o(),
        .release_base_o(), .release_mask_o(rm), .pass_valid_o, .pass_kind_o,
        .spawn_valid_o, .object_kind_field_o, .hdr_dw2_o, .hdr_dw3_o,
        .hdr_dw4_o, .hdr_dw5_o, .hdr_dw6_o, .thread_done_i);
    cpb_decider u_dec (.core_clk_i, .nrst_i, .obj_valid_o, .spawn_valid_o,
        .decision_valid_i, .clip_action_select_i, .thread_done_i);
    always #4 core_clk_i = ~core_clk_i;
    // Nibbles: stride, offsets 0..2, span, vertices
    function automatic logic [23:0] shp(input logic [4:0] k);
        case (k)
            5'h01, 5'h19: return 24'h100001;
            5'h02: return 24'h201012;
            5'h10: return 24'h412032;
            5'h03, 5'h16, 5'h17, 5'h18: return 24'h101012;
            5'h11: return 24'h112032;
            5'h05, 5'h0F: return 24'h301223;
            5'h12: return 24'h602453;
            5'h13: return 24'h202453;
            default: return 24'h101223;
        endcase
    endfunction
    function automatic logic [4:0] lbl(input logic [4:0] k, input int n);
        case (k)
            5'h06, 5'h13: return n[0] ? 5'h14 : 5'h06;
            5'h14: return n[0] ? 5'h06 : 5'h14;
            5'h10: return 5'h02;
            5'h11: return 5'h03;
            5'h12: return 5'h05;
            default: return k;
        endcase
    endfunction
    function automatic logic [18:0] oc(input int i);
        return 19'h00001 << (i % 19);
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            miscompares++;
        end
    endtask
    task summarize;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task send(input logic [4:0] k, input int n);
        int i;
        logic [23:0] s;
        i = 0;
        s = shp(k);
        ck = k;
        j = 0;
        @(posedge core_clk_i);
        prim_valid_i <= 1'b1;
        primitive_kind_i <= k;
        prim_count_i <= 7'(n);
        do @(posedge core_clk_i); while (prim_ready_o !== 1'b1);
        prim_valid_i <= 1'b0;
        vtx_valid_i <= 1'b1;
        vtx_outcode_i <= oc(0);
        while (i < n)
        begin
            @(posedge core_clk_i);
            i += int'(vtx_ready_o === 1'b1);
            vtx_outcode_i <= oc(i);
        end
        vtx_valid_i <= 1'b0;
        do @(posedge core_clk_i); while (prim_ready_o !== 1'b1);
        chk("count", (n - s[7:4] - 1) / s[23:20] + 1, j);
    endtask
    always @(posedge core_clk_i)
    begin
        logic [23:0] s;
        int v0, v1, v2;
        s = shp(ck);
        v1 = s[23:20] * j + s[15:12];
        v2 = s[23:20] * j + s[11:8];
        v0 = (ck inside {5'h07, 5'h15, 5'h0C}) ? 0 : s[23:20] * j + s[19:16];
        if (pend)
        begin
            chk("pass", pa == 2'h0, pass_valid_o);
            chk("spawn", pa == 2'h2, spawn_valid_o);
            if (pa == 2'h0)
                chk("pass_kind", pl, pass_kind_o);
            if (pa == 2'h2 && !(ck inside {5'h10, 5'h11, 5'h12}))
                chk("obj_kind", pl, object_kind_field_o);
            if (pa == 2'h2)
            begin
                chk("dw3", 32'hB, hdr_dw3_o);
                chk("dw4", 32'hFFFFFFE0, hdr_dw4_o);
                chk("dw5", 32'hFFFFFC, hdr_dw5_o[31:8]);
            end
        end
        pend <= obj_valid_o && decision_valid_i;
        pa <= clip_action_select_i;
        pl <= lbl(ck, j);
        if (obj_valid_o && decision_valid_i)
        begin
            j <= j + 1;
            chk("v0", v0, obj_v0_o);
            chk("nv", s[3:0], obj_nverts_o);
            if (s[3:0] > 4'h1)
                chk("v1", v1, obj_v1_o);
            if (s[3:0] > 4'h2)
                chk("v2", v2, obj_v2_o);
            if (ck == 5'h12)
                chk("rel", 6'h2A, rm);
            chk("or", oc(v0) | (s[3:0] > 4'h1 ? oc(v1) : 19'h0) |
                (s[3:0] > 4'h2 ? oc(v2) : 19'h0), obj_or_code_o);
        end
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        logic [31:0] r;
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        ahb(1'b1, 8'h04, 32'hFFFFFFFF, r);
        ahb(1'b1, 8'h08, 32'hFFFFFFFF, r);
        ahb(1'b1, 8'h0C, 32'h0000000F, r);
        ahb(1'b0, 8'h0C, 32'h0, r);
        chk("size_sat", 32'hB, r);
        ahb(1'b0, 8'h40, 32'h0, r);
        chk("unmapped", 32'h0, r);
        ahb(1'b1, 8'h00, 32'h1, r);
        for (int t = 0; t < 18; t++)
            send(kinds[t], cnts[t]);
        summarize();
    end
endmodule // clip_passthru_payload_builder_test
